// >>> pkg/lifc_regs.vh
// register map, field positions and limits of the line image format block
// assumes a 32-bit AHB-Lite slave decoding byte offsets in haddr[7:0]
`ifndef LIFC_REGS_VH
`define LIFC_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define LIFC_CTRL_OFF   8'h00
`define LIFC_ROI_OFF    8'h04
`define LIFC_HGT_OFF    8'h08
`define LIFC_STAT_OFF   8'h0c

// ****************************************
// field positions
// ****************************************
`define LIFC_GEOM_BIT   0
`define LIFC_DIR_BIT    1
`define LIFC_STG_LSB    2
`define LIFC_LAY_LSB    4
`define LIFC_EN_BIT     8
`define LIFC_WID_LSB    16
`define LIFC_LINE_LSB   16

// ****************************************
// reset values and limits
// ****************************************
`define LIFC_CTRL_RST   9'h000
`define LIFC_SENS_W     12'h870
`define LIFC_GRAN       12'h030
`define LIFC_START_MAX  12'h840
`define LIFC_HGT_MAX    13'h1000
`define LIFC_HGT_RST    13'h1000
`define LIFC_LAY_MAX    3'h5

// ****************************************
// stage counts
// ****************************************
`define LIFC_STG20      7'h14
`define LIFC_STG40      7'h28
`define LIFC_STG60      7'h3c
`define LIFC_STG80      7'h50

`endif

// >>> logic/lifc_skid.v
// two-entry buffer between the cropper and the stream output
// assumes one clock; all outputs come from flip-flops
`timescale 1ns/100ps

module lifc_skid #(
    parameter W = 38
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire         in_valid,
    input  wire [W-1:0] in_data,
    output reg          in_ready,
    output reg          out_valid,
    output reg  [W-1:0] out_data,
    input  wire         out_ready
);

    reg  [W-1:0] spare;
    reg          spare_v;
    reg          next_spare_v;

    // ****************************************
    // occupancy
    // ****************************************
    always @* begin
        next_spare_v = spare_v;
        if (!out_valid || out_ready)
            next_spare_v = 1'b0;
        else if (in_valid && in_ready)
            next_spare_v = 1'b1;
    end

    // registered ready costs the spare slot, keeps timing short
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spare     <= {W{1'b0}};
            spare_v   <= 1'b0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= {W{1'b0}};
        end else begin
            spare_v  <= next_spare_v;
            in_ready <= ~next_spare_v;
            if (!out_valid || out_ready) begin
                if (spare_v) begin
                    out_data  <= spare;
                    out_valid <= 1'b1;
                end else begin
                    out_data  <= in_data;
                    out_valid <= in_valid;
                end
            end else if (in_valid && in_ready) begin
                spare <= in_data;
            end
        end
    end

endmodule // lifc_skid

// >>> logic/lifc_top.v
// line image format control: geometry, crop, framing, output layout
// assumes sensor stream on hclk, sensor sends 2160 pixels per row
`timescale 1ns/100ps
`include "lifc_regs.vh"

module lifc_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire        sens_valid,
    input  wire [35:0] sens_data,
    output wire        sens_ready,
    output reg         sens_area,
    output reg         sens_shift_reverse,
    output reg  [6:0]  sens_stages,
    output reg  [6:0]  sens_row,
    output wire        out_valid,
    output wire [35:0] out_data,
    output wire        out_sof,
    output wire        out_eol,
    input  wire        out_ready
);

    // ****************************************
    // decoding helpers
    // ****************************************
    function [6:0] stage_rows;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    stage_rows = `LIFC_STG20;
                2'h1:    stage_rows = `LIFC_STG40;
                2'h2:    stage_rows = `LIFC_STG60;
                default: stage_rows = `LIFC_STG80;
            endcase
        end
    endfunction

    function is_mult48;
        input [11:0] v;
        begin
            is_mult48 = ((v % `LIFC_GRAN) == 12'h000);
        end
    endfunction

    // ****************************************
    // software registers
    // ****************************************
    reg  [8:0]  ctrl;
    reg  [11:0] roi_start_column;
    reg  [11:0] roi_width;
    reg  [12:0] frame_height;
    reg         cfg_err;

    // active copy, swapped at frame boundaries and on every cycle while disabled
    reg         a_geom;
    reg         a_dir;
    reg  [1:0]  a_stg;
    reg  [2:0]  a_lay;
    reg  [11:0] a_start;
    reg  [11:0] a_width;
    reg  [12:0] a_height;

    reg  [11:0] col;
    reg  [12:0] line;

    // ****************************************
    // bus slave
    // ****************************************
    reg         w_pend;
    reg         r_pend;
    reg  [7:0]  b_addr;
    wire        take = hsel & htrans[1] & hready;
    wire [11:0] w_start = hwdata[11:0];
    wire [11:0] w_width = hwdata[`LIFC_WID_LSB+11:`LIFC_WID_LSB];
    wire [12:0] w_hgt   = hwdata[12:0];
    wire [12:0] w_end   = {1'b0, w_start} + {1'b0, w_width};
    wire        roi_ok  = is_mult48(w_start) && is_mult48(w_width)
                        && w_start <= `LIFC_START_MAX
                        && w_width != 12'h000
                        && w_end <= {1'b0, `LIFC_SENS_W};
    wire        hgt_ok  = w_hgt != 13'h0000 && w_hgt <= `LIFC_HGT_MAX;
    wire        lay_ok  = hwdata[`LIFC_LAY_LSB+2:`LIFC_LAY_LSB]
                        <= `LIFC_LAY_MAX;
    // the enabling write itself must reach the active copy
    wire [8:0]  ctrl_next = (w_pend && b_addr == `LIFC_CTRL_OFF && lay_ok)
                          ? hwdata[8:0] : ctrl;

    // reads take one wait state so a preceding write is always seen
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_pend    <= 1'b0;
            r_pend    <= 1'b0;
            b_addr    <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            w_pend    <= take & hwrite;
            r_pend    <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
            if (take)
                b_addr <= haddr[7:0];
            if (r_pend) begin
                case (b_addr)
                    `LIFC_CTRL_OFF: hrdata <= {23'h000000, ctrl};
                    `LIFC_ROI_OFF:  hrdata <= {4'h0, roi_width,
                                               4'h0, roi_start_column};
                    `LIFC_HGT_OFF:  hrdata <= {19'h00000, frame_height};
                    `LIFC_STAT_OFF: hrdata <= {3'h0, line, 13'h0000,
                                               a_geom, ctrl[`LIFC_EN_BIT],
                                               cfg_err};
                    default:        hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // bad settings are refused whole and flagged, old value stays
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl             <= `LIFC_CTRL_RST;
            roi_start_column <= 12'h000;
            roi_width        <= `LIFC_SENS_W;
            frame_height     <= `LIFC_HGT_RST;
            cfg_err          <= 1'b0;
        end else if (w_pend) begin
            case (b_addr)
                `LIFC_CTRL_OFF: begin
                    if (lay_ok)
                        ctrl <= hwdata[8:0];
                    else
                        cfg_err <= 1'b1;
                end
                `LIFC_ROI_OFF: begin
                    if (roi_ok) begin
                        roi_start_column <= w_start;
                        roi_width        <= w_width;
                    end else begin
                        cfg_err <= 1'b1;
                    end
                end
                `LIFC_HGT_OFF: begin
                    if (hgt_ok)
                        frame_height <= w_hgt;
                    else
                        cfg_err <= 1'b1;
                end
                `LIFC_STAT_OFF: begin
                    if (hwdata[0])
                        cfg_err <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // framing counters
    // ****************************************
    wire        en        = ctrl[`LIFC_EN_BIT];
    wire [6:0]  a_rows    = stage_rows(a_stg);
    wire [12:0] frame_len = a_geom ? {6'h00, a_rows} : a_height;
    wire [12:0] roi_end   = {1'b0, a_start} + {1'b0, a_width};
    wire        in_roi    = col >= a_start && {1'b0, col} < roi_end;
    wire        last_col  = col == `LIFC_SENS_W - 12'h001;
    wire        last_line = line == frame_len - 13'h0001;
    wire        skid_in_ready;
    wire        beat      = sens_valid & en & skid_in_ready;
    wire        frame_end = beat & last_col & last_line;
    wire        load_cfg  = ~en | frame_end;
    reg  [12:0] next_line;

    always @* begin
        next_line = line;
        if (beat && last_col)
            next_line = last_line ? 13'h0000 : line + 13'h0001;
        if (!en)
            next_line = 13'h0000;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            col  <= 12'h000;
            line <= 13'h0000;
        end else begin
            line <= next_line;
            if (!en)
                col <= 12'h000;
            else if (beat)
                col <= last_col ? 12'h000 : col + 12'h001;
        end
    end

    // changing geometry mid-frame would tear the image
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_geom   <= 1'b0;
            a_dir    <= 1'b0;
            a_stg    <= 2'h0;
            a_lay    <= 3'h0;
            a_start  <= 12'h000;
            a_width  <= `LIFC_SENS_W;
            a_height <= `LIFC_HGT_RST;
        end else if (load_cfg) begin
            a_geom   <= ctrl_next[`LIFC_GEOM_BIT];
            a_dir    <= ctrl_next[`LIFC_DIR_BIT];
            a_stg    <= ctrl_next[`LIFC_STG_LSB+1:`LIFC_STG_LSB];
            a_lay    <= ctrl_next[`LIFC_LAY_LSB+2:`LIFC_LAY_LSB];
            a_start  <= roi_start_column;
            a_width  <= roi_width;
            a_height <= frame_height;
        end
    end

    // ****************************************
    // sensor control outputs
    // ****************************************
    wire [6:0] next_rows =
        stage_rows(ctrl_next[`LIFC_STG_LSB+1:`LIFC_STG_LSB]);
    wire [6:0] cur_rows  = load_cfg ? next_rows : a_rows;
    wire       cur_dir   = load_cfg ? ctrl_next[`LIFC_DIR_BIT] : a_dir;
    wire       cur_geom  = load_cfg ? ctrl_next[`LIFC_GEOM_BIT] : a_geom;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sens_area          <= 1'b0;
            sens_shift_reverse <= 1'b0;
            sens_stages        <= `LIFC_STG20;
            sens_row           <= 7'h00;
        end else begin
            sens_area          <= cur_geom;
            sens_shift_reverse <= ~cur_geom & cur_dir;
            sens_stages        <= cur_rows;
            if (!cur_geom)
                sens_row <= 7'h00;
            else if (cur_dir)
                sens_row <= cur_rows - 7'h01 - next_line[6:0];
            else
                sens_row <= next_line[6:0];
        end
    end

    // ****************************************
    // output layout
    // ****************************************
    // slot 0 sits at the top of the word, narrow depths in low bits
    wire [35:0] fmt;
    wire        bgr   = a_lay >= 3'h3;
    wire [1:0]  depth = bgr ? a_lay[1:0] - 2'h3 : a_lay[1:0];

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_slot
            wire [11:0] src = bgr ? sens_data[12*i+11:12*i]
                                  : sens_data[35-12*i:24-12*i];
            assign fmt[35-12*i:24-12*i] =
                (depth == 2'h0) ? {4'h0, src[11:4]} :
                (depth == 2'h1) ? {2'h0, src[11:2]} : src;
        end
    endgenerate

    wire sof = line == 13'h0000 && col == a_start;
    wire eol = {1'b0, col} == roi_end - 13'h0001;

    lifc_skid #(
        .W(38)
    ) u_skid (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (sens_valid & en & in_roi),
        .in_data   ({sof, eol, fmt}),
        .in_ready  (skid_in_ready),
        .out_valid (out_valid),
        .out_data  ({out_sof, out_eol, out_data}),
        .out_ready (out_ready)
    );

    // receiver stall holds the sensor, so no pixel is dropped
    assign sens_ready = skid_in_ready;

endmodule // lifc_top

// >>> dv/lifc_monitor.sv
// checker: bus answer timing, sensor controls, stream framing
// assumes bound to lifc_top, one clock domain on hclk
`timescale 1ns/100ps
module lifc_monitor (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        sens_area,
    input wire        sens_shift_reverse,
    input wire [6:0]  sens_stages,
    input wire [6:0]  sens_row,
    input wire        out_valid,
    input wire [35:0] out_data,
    input wire        out_sof,
    input wire        out_eol,
    input wire        out_ready
);
// ****************
// properties
// ****************
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
logic [11:0] beats;
wire         tk  = out_valid && out_ready;
wire         req = hsel && htrans[1] && hready;
// beats taken since the last end of line
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) beats <= 12'h000;
    else if (tk) beats <= out_eol ? 12'h000 : beats + 12'h001;
end
sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
property p_rd_wait; req && !hwrite |=> s_rd_ans; endproperty
a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
property p_wr_fast; req && hwrite |=> hreadyout; endproperty
a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
property p_stages;
    sens_stages inside {7'h14, 7'h28, 7'h3c, 7'h50};
endproperty
a_stages: assert property (p_stages) else $error("bad stages");
property p_line_row; !sens_area |-> sens_row == 7'h00; endproperty
a_line_row: assert property (p_line_row) else $error("row in line");
property p_area_row; sens_area |-> sens_row < sens_stages; endproperty
a_area_row: assert property (p_area_row) else $error("row range");
property p_area_shift; sens_area |-> !sens_shift_reverse; endproperty
a_area_shift: assert property (p_area_shift) else $error("shift");
property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data)
        && $stable(out_sof) && $stable(out_eol);
endproperty
a_hold: assert property (p_hold) else $error("beat not held");
property p_eol_gran; tk && out_eol |-> beats % 12'd48 == 12'd47; endproperty
a_eol_gran: assert property (p_eol_gran) else $error("line length");
property p_sof_first; out_valid && out_sof |-> beats == 12'h000; endproperty
a_sof_first: assert property (p_sof_first) else $error("sof place");
endmodule // lifc_monitor
bind lifc_top lifc_monitor u_lifc_monitor (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .sens_area, .sens_shift_reverse,
    .sens_stages, .sens_row, .out_valid, .out_data, .out_sof, .out_eol,
    .out_ready);

// >>> dv/lifc_host.sv
// host receiver model: collects stream beats in a queue
// assumes beats on hclk; the bench sets slow to make it stall
`timescale 1ns/100ps
module lifc_host (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        out_valid,
    input  wire [35:0] out_data,
    input  wire        out_sof,
    input  wire        out_eol,
    output logic       out_ready = 1'b0
);
// ****************
// sink
// ****************
logic        slow = 1'b0;
logic [37:0] q[$];
// slow mode fills the buffer so the sensor side must back off
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) out_ready <= 1'b0;
    else begin
        if (out_valid && out_ready) q.push_back({out_sof, out_eol, out_data});
        out_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
    end
end
endmodule // lifc_host

// >>> dv/test_line_image_format_control.sv
// testbench: bus master, sensor driver, beat model and verdict
// assumes lifc_top, the lifc_host sink and the bound lifc_monitor
`timescale 1ns/100ps
module test_line_image_format_control;
// ****************
// bench
// ****************
logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sens_valid = 0;
logic [31:0] haddr = 0, hwdata = 0, rv;
logic [1:0]  htrans = 0;
logic [35:0] sens_data = 0;
wire         hreadyout, hresp, sens_ready, sens_area, sens_shift_reverse;
wire         out_valid, out_sof, out_eol, out_ready;
wire  [31:0] hrdata;
wire  [6:0]  sens_stages, sens_row;
wire  [35:0] out_data;
logic [37:0] exq[$];
int          err_count = 0, checks_done = 0, cyc = 0;
int          rs[3] = '{2112, 0, 48};
int          rw[3] = '{48, 2160, 288};
logic [7:0]  ba[6] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h00};
logic [31:0] bd[6] = '{32'h0030_0018, 32'h0, 32'h0060_0840, 32'h0,
                       32'h1001, 32'h60};
always #2 hclk = ~hclk;
lifc_top u_lifc_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .sens_valid, .sens_data, .sens_ready, .sens_area, .sens_shift_reverse,
    .sens_stages, .sens_row, .out_valid, .out_data, .out_sof, .out_eol,
    .out_ready);
lifc_host u_lifc_host (.hclk, .hresetn, .out_valid, .out_data, .out_sof,
    .out_eol, .out_ready);
task complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
task miss(input string m);
    err_count++;
    $display("MISMATCH %0t %s", $time, m);
endtask
task chk_reg(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) miss($sformatf("value %h exp %h", g, e));
endtask
task chk_beat(input logic [37:0] g, e);
    checks_done++;
    if (g !== e) miss($sformatf("beat %h exp %h", g, e));
endtask
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rv = hrdata;
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk_reg(rv, e);
    chk_reg({31'h0, hresp}, 32'h0);
endtask
// 12-bit samples cut to the layout depth, top bits kept
function automatic logic [35:0] fmt(logic [35:0] p, int l);
    logic [11:0] a, b, g;
    int          sh;
    sh = 4 - 2 * (l % 3);
    a = (l > 2) ? p[11:0] : p[35:24];
    b = (l > 2) ? p[35:24] : p[11:0];
    g = p[23:12];
    return {a >> sh, g >> sh, b >> sh};
endfunction
task rows(input int st, wd, lay, h, n);
    logic [35:0] p;
    for (int r = 0; r < n; r++) begin
        for (int c = 0; c < 2160; c++) begin
            p[31:0] = $urandom;
            p[35:32] = 4'($urandom);
            sens_valid <= 1;
            sens_data <= p;
            @(posedge hclk);
            while (!sens_ready) @(posedge hclk);
            if (c >= st && c < st + wd)
                exq.push_back({r % h == 0 && c == st, c == st + wd - 1,
                               fmt(p, lay)});
        end
    end
    sens_valid <= 0;
endtask
task drain;
    for (int i = 0; i < 9000 && u_lifc_host.q.size() != exq.size(); i++)
        @(posedge hclk);
    chk_reg(u_lifc_host.q.size(), exq.size());
    while (exq.size() && u_lifc_host.q.size())
        chk_beat(u_lifc_host.q.pop_front(), exq.pop_front());
    exq.delete();
    u_lifc_host.q.delete();
endtask
always @(posedge hclk) begin
    cyc++;
    if (cyc == 80000) begin
        miss("timeout");
        complete_run;
    end
end
initial begin
    void'($urandom(32'h9985));
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0870_0000);
    rd(8'h08, 32'h1000);
    rd(8'h10, 32'h0);
    chk_reg({25'h0, sens_stages}, 32'd20);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
        bus(1, 8'h00, 32'(s * 4 + 2));
        rd(8'h00, 32'(s * 4 + 2));
        chk_reg({25'h0, sens_stages}, 32'(20 + 20 * s));
        chk_reg({31'h0, sens_shift_reverse}, 32'h1);
    end
    bus(1, 8'h00, 32'h0f);
    rd(8'h00, 32'h0f);
    chk_reg({31'h0, sens_area}, 32'h1);
    chk_reg({25'h0, sens_row}, 32'd79);
    bus(1, 8'h00, 32'h0d);
    rd(8'h00, 32'h0d);
    chk_reg({25'h0, sens_row}, 32'h0);
    bus(1, 8'h00, 32'h0);
    $display("test geometry done");
    for (int i = 0; i < 6; i++) begin
        bus(1, ba[i], bd[i]);
        rd(ba[i], i < 3 ? 32'h0870_0000 : i < 5 ? 32'h1000 : 32'h0);
        rd(8'h0c, 32'h1);
        bus(1, 8'h0c, 32'h1);
    end
    rd(8'h0c, 32'h0);
    $display("test refusal done");
    bus(1, 8'h08, 32'h1);
    for (int l = 0; l < 6; l++) begin
        u_lifc_host.slow = l[0];
        bus(1, 8'h04, 32'(rw[l % 3] << 16 | rs[l % 3]));
        bus(1, 8'h00, 32'(32'h100 | l << 4));
        rows(rs[l % 3], rw[l % 3], l, 1, 1);
        drain;
        bus(1, 8'h00, 32'h0);
    end
    $display("test layouts done");
    bus(1, 8'h08, 32'h2);
    bus(1, 8'h04, 32'h0030_0030);
    bus(1, 8'h00, 32'h120);
    rows(48, 48, 2, 2, 3);
    drain;
    $display("test frames done");
    complete_run;
end
endmodule // test_line_image_format_control
